// file: shared/vr_prot_defines.svh
`ifndef VR_PROT_DEFINES_SVH
`define VR_PROT_DEFINES_SVH

// ----------------------------------------------------------------
// register command codes
// ----------------------------------------------------------------
`define REG_PROTECT_CFG    8'h90
`define REG_OV_UV_DELAY    8'h91
`define REG_OC_DELAY       8'h93
`define REG_ABS_OV_LEVEL   8'h95
`define REG_VALLEY_LIMIT   8'h97
`define REG_TOTAL_LIMIT    8'h98
`define REG_OFFSET_A       8'hEB
`define REG_OFFSET_B       8'hEC
`define REG_OFFSET_C       8'hED

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define OV2_MODE_MSB       5
`define OV2_MODE_LSB       4
`define UV1_MODE_BIT       7
`define UV2_MODE_MSB       9
`define UV2_MODE_LSB       8
`define OV2_DLY_MSB        11
`define OV2_DLY_LSB        6
`define UV2_DLY_MSB        5
`define UV2_DLY_LSB        0
`define OC_DLY_MSB         5
`define OC_DLY_LSB         0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_PROTECT_CFG    16'h0000
`define RST_DELAY          16'h0000
`define RST_LEVEL          16'h0FFF
`define RST_OFFSET         16'h0000

// ----------------------------------------------------------------
// levels and timing
// ----------------------------------------------------------------
`define RVP_LEVEL          12'h010
`define UV1_LEVEL          12'h0C8
`define UV2_MARGIN         12'h050
`define CODE_MAX           12'h280
`define FINE_STEP_UV       2500
`define COARSE_STEP_UV     5000
`define CLK_PERIOD_NS      5
`define DELAY_LSB_NS       1000
`define DELAY_TICK_CYCLES  ((`DELAY_LSB_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: shared/vr_pkg.sv
package vr_pkg;

  typedef enum logic [1:0] {RUN, TRACK_LOW, TRI_LATCH} rail_state_t;

  typedef struct packed {
    logic [15:0] cfg;
    logic [15:0] dly;
    logic [15:0] oc_dly;
    logic [15:0] abs_lvl;
    logic [15:0] valley;
    logic [15:0] total;
  } rail_regs_t;

  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_t;

  typedef struct packed {
    logic [11:0] volt;
    logic [11:0] ref_code;
    logic [11:0] total_current;
    logic [11:0] voltage_code;
    logic [11:0] temperature;
    logic        soft_start;
    logic        shutdown;
    logic        ramp;
  } rail_meas_t;

  typedef struct packed {
    rail_regs_t [1:0]       regs;
    logic [2:0][15:0]       offs;
    rail_state_t [1:0]      st;
    logic [1:0]             abs_latch;
    logic [1:0]             started;
    logic [1:0]             hot;
    logic [7:0]             tick_cnt;
    logic                   tick;
    logic [5:0]             req_prev;
    logic [5:0]             block;
    logic [5:0]             pwm_out;
    logic [5:0]             pwm_oe;
    logic [5:0][11:0]       cs_adj;
    logic [1:0][21:0]       target_uv;
    logic [15:0]            rdata;
    logic                   rvalid;
    pin_drive_t [1:0]       stby;
    pin_drive_t [1:0]       fault;
    pin_drive_t [1:0]       trans;
    pin_drive_t [1:0]       hot_pin;
    logic [1:0]             ready;
  } core_state_t;

endpackage

// file: rtl/pin_sync.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// three-stage pin synchroniser, change taken when stages two and three agree
// ----------------------------------------------------------------
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // pins in, filtered levels out
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] level;
  } sync_state_t;

  sync_state_t s;
  sync_state_t next_s;

  always_comb begin
    next_s       = s;
    next_s.s1    = pin;
    next_s.s2    = s.s1;
    next_s.s3    = s.s2;
    // a one-cycle glitch between stages two and three never reaches level
    next_s.level = (~(s.s2 ^ s.s3) & s.s3) | ((s.s2 ^ s.s3) & s.level);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level = s.level;

endmodule // pin_sync

// file: rtl/persist_filter.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// condition must hold for delay+1 ticks before trip rises
// ----------------------------------------------------------------
module persist_filter (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // timing
  input  wire logic       tick,
  input  wire logic [5:0] delay,
  // condition
  input  wire logic       cond,
  input  wire logic       clear,
  output logic            trip
);

  typedef struct packed {
    logic [5:0] cnt;
    logic       trip;
  } filt_state_t;

  filt_state_t s;
  filt_state_t next_s;

  always_comb begin
    next_s = s;
    if (clear || !cond) begin
      next_s.cnt  = 6'h00;
      next_s.trip = 1'b0;
    end else if (tick) begin
      if (s.cnt >= delay) begin
        next_s.trip = 1'b1;
      end else begin
        next_s.cnt = s.cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign trip = s.trip;

endmodule // persist_filter

// file: rtl/vr_rail_protection_status.sv
`timescale 1ns/1ps
`include "vr_prot_defines.svh"

module vr_rail_protection_status (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     resetn,
  // register port
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  input  wire logic                     reg_page,
  input  wire logic [7:0]               reg_cmd,
  input  wire logic [15:0]              reg_wdata,
  output logic      [15:0]              reg_rdata,
  output logic                          reg_rvalid,
  // control pins
  input  wire logic [1:0]               enable_pin,
  input  wire logic                     supply_ok_pin,
  input  wire logic [1:0]               standby_pin,
  // static configuration
  input  wire logic                     standby_tristate,
  input  wire logic                     gpio_combine,
  input  wire logic                     fine_step,
  input  wire logic [11:0]              hot_level,
  input  wire logic [11:0]              hot_hyst,
  // rail measurements
  input  wire vr_pkg::rail_meas_t [1:0] rail_meas,
  // phases, 0..2 on rail 0 and 3..5 on rail 1
  input  wire logic [5:0]               pwm_req,
  input  wire logic [5:0][11:0]         phase_cs,
  output logic      [5:0]               pwm_out,
  output logic      [5:0]               pwm_oe,
  output logic      [5:0][11:0]         phase_cs_adj,
  // indicators
  output vr_pkg::pin_drive_t [1:0]      stage_standby_out,
  output vr_pkg::pin_drive_t [1:0]      fault_out,
  output vr_pkg::pin_drive_t [1:0]      transition_out,
  output vr_pkg::pin_drive_t [1:0]      overtemp_flag,
  output logic      [1:0]               rail_ready_out,
  output logic      [1:0][21:0]         target_uv
);

  vr_pkg::core_state_t s;
  vr_pkg::core_state_t next_s;

  logic [4:0]        pin_level;
  logic [1:0]        en_rail;
  logic [1:0]        standby_req;
  logic [1:0]        ov2_cond;
  logic [1:0]        ov2_blank;
  logic [1:0]        ov2_trip;
  logic [1:0]        oc_cond;
  logic [1:0]        oc_trip;
  logic [1:0]        uv1_low;
  logic [1:0]        uv2_low;
  logic [1:0]        uv_cond;
  logic [1:0]        uv_blank;
  logic [1:0]        uv_trip;
  logic [1:0]        uv_latch;
  logic [1:0]        rail_fault;
  logic [1:0][11:0]  code_clamped;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  pin_sync #(
    .W (5)
  ) u_pin_sync (
    .clk    (clk),
    .resetn (resetn),
    .pin    ({standby_pin, supply_ok_pin, enable_pin}),
    .level  (pin_level)
  );

  assign standby_req = pin_level[4:3];

  // ----------------------------------------------------------------
  // per-rail fault detectors
  // ----------------------------------------------------------------
  for (genvar r = 0; r < 2; r++) begin : g_rail
    // dropping either enable or supply is the toggle that frees the latches
    assign en_rail[r] = pin_level[r] & pin_level[2];

    // modes 1x disable the tracking overvolt check
    assign ov2_cond[r] = !s.regs[r].cfg[`OV2_MODE_MSB]
                       && (rail_meas[r].volt > rail_meas[r].ref_code);
    assign ov2_blank[r] = rail_meas[r].soft_start | rail_meas[r].shutdown
                        | rail_meas[r].ramp;

    persist_filter u_ov2 (
      .clk    (clk),
      .resetn (resetn),
      .tick   (s.tick),
      .delay  (s.regs[r].dly[`OV2_DLY_MSB:`OV2_DLY_LSB]),
      .cond   (ov2_cond[r]),
      .clear  (!en_rail[r] || ov2_blank[r]),
      .trip   (ov2_trip[r])
    );

    assign oc_cond[r] = rail_meas[r].total_current > s.regs[r].total[11:0];

    persist_filter u_oc (
      .clk    (clk),
      .resetn (resetn),
      .tick   (s.tick),
      .delay  (s.regs[r].oc_dly[`OC_DLY_MSB:`OC_DLY_LSB]),
      .cond   (oc_cond[r]),
      .clear  (!en_rail[r]),
      .trip   (oc_trip[r])
    );

    assign uv1_low[r] = s.regs[r].cfg[`UV1_MODE_BIT]
                      && (rail_meas[r].volt < `UV1_LEVEL);
    // tracking floor sits a fixed margin under the reference, never below zero
    assign uv2_low[r] = !s.regs[r].cfg[`UV2_MODE_MSB]
                      && ({1'b0, rail_meas[r].volt} + {1'b0, `UV2_MARGIN}
                          < {1'b0, rail_meas[r].ref_code});
    assign uv_cond[r]  = uv1_low[r] | uv2_low[r];
    // the output starts from zero, so undervolt waits for soft start to end
    assign uv_blank[r] = rail_meas[r].soft_start | rail_meas[r].shutdown;

    persist_filter u_uv (
      .clk    (clk),
      .resetn (resetn),
      .tick   (s.tick),
      .delay  (s.regs[r].dly[`UV2_DLY_MSB:`UV2_DLY_LSB]),
      .cond   (uv_cond[r]),
      .clear  (!en_rail[r] || uv_blank[r]),
      .trip   (uv_trip[r])
    );

    // tracking mode 01 only reports; the fixed level always acts
    assign uv_latch[r] = uv_trip[r]
                      && (uv1_low[r] || s.regs[r].cfg[`UV2_MODE_LSB] == 1'b0);

    assign rail_fault[r] = s.abs_latch[r] || (s.st[r] != vr_pkg::RUN)
                        || ov2_trip[r] || oc_trip[r] || uv_trip[r];

    assign code_clamped[r] = (rail_meas[r].voltage_code > `CODE_MAX) ? `CODE_MAX
                           : rail_meas[r].voltage_code;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s        = s;
    next_s.rvalid = 1'b0;

    // delay tick shared by all persistence filters
    if (s.tick_cnt == 8'(`DELAY_TICK_CYCLES - 1)) begin
      next_s.tick_cnt = 8'h00;
      next_s.tick     = 1'b1;
    end else begin
      next_s.tick_cnt = s.tick_cnt + 8'h01;
      next_s.tick     = 1'b0;
    end

    // register writes
    if (reg_wr) begin
      case (reg_cmd)
        `REG_PROTECT_CFG:  next_s.regs[reg_page].cfg     = reg_wdata;
        `REG_OV_UV_DELAY:  next_s.regs[reg_page].dly     = reg_wdata;
        `REG_OC_DELAY:     next_s.regs[reg_page].oc_dly  = reg_wdata;
        `REG_ABS_OV_LEVEL: next_s.regs[reg_page].abs_lvl = reg_wdata;
        `REG_VALLEY_LIMIT: next_s.regs[reg_page].valley  = reg_wdata;
        `REG_TOTAL_LIMIT:  next_s.regs[reg_page].total   = reg_wdata;
        `REG_OFFSET_A:     next_s.offs[0]                = reg_wdata;
        `REG_OFFSET_B:     next_s.offs[1]                = reg_wdata;
        `REG_OFFSET_C:     next_s.offs[2]                = reg_wdata;
        default: begin
        end
      endcase
    end

    // register reads, unmapped codes answer zero
    if (reg_rd) begin
      next_s.rvalid = 1'b1;
      case (reg_cmd)
        `REG_PROTECT_CFG:  next_s.rdata = s.regs[reg_page].cfg;
        `REG_OV_UV_DELAY:  next_s.rdata = s.regs[reg_page].dly;
        `REG_OC_DELAY:     next_s.rdata = s.regs[reg_page].oc_dly;
        `REG_ABS_OV_LEVEL: next_s.rdata = s.regs[reg_page].abs_lvl;
        `REG_VALLEY_LIMIT: next_s.rdata = s.regs[reg_page].valley;
        `REG_TOTAL_LIMIT:  next_s.rdata = s.regs[reg_page].total;
        `REG_OFFSET_A:     next_s.rdata = s.offs[0];
        `REG_OFFSET_B:     next_s.rdata = s.offs[1];
        `REG_OFFSET_C:     next_s.rdata = s.offs[2];
        default:           next_s.rdata = 16'h0000;
      endcase
    end

    // ----------------------------------------------------------------
    // protection state, one copy per rail
    // ----------------------------------------------------------------
    for (int r = 0; r < 2; r++) begin
      if (!en_rail[r]) begin
        next_s.abs_latch[r] = 1'b0;
        next_s.st[r]        = vr_pkg::RUN;
      end else begin
        next_s.started[r] = 1'b1;
        // checked in every state, fault or not
        if (rail_meas[r].volt > s.regs[r].abs_lvl[11:0]) begin
          next_s.abs_latch[r] = 1'b1;
        end
        case (s.st[r])
          vr_pkg::RUN: begin
            if (oc_trip[r] || uv_latch[r]) begin
              next_s.st[r] = vr_pkg::TRI_LATCH;
            end else if (ov2_trip[r]
                         && s.regs[r].cfg[`OV2_MODE_MSB:`OV2_MODE_LSB] == 2'b00) begin
              next_s.st[r] = vr_pkg::TRACK_LOW;
            end else if (s.abs_latch[r] && rail_meas[r].volt < `RVP_LEVEL) begin
              next_s.st[r] = vr_pkg::TRI_LATCH;
            end
          end
          vr_pkg::TRACK_LOW: begin
            // held low until the ringing reaches the reverse threshold
            if (rail_meas[r].volt < `RVP_LEVEL || oc_trip[r] || uv_latch[r]) begin
              next_s.st[r] = vr_pkg::TRI_LATCH;
            end
          end
          vr_pkg::TRI_LATCH: begin
            next_s.st[r] = vr_pkg::TRI_LATCH;
          end
          default: begin
            next_s.st[r] = vr_pkg::TRI_LATCH;
          end
        endcase
      end

      // overtemp with hysteresis; it never touches the rail state
      if (rail_meas[r].temperature > hot_level) begin
        next_s.hot[r] = 1'b1;
      end else if ({1'b0, rail_meas[r].temperature} + {1'b0, hot_hyst}
                   < {1'b0, hot_level}) begin
        next_s.hot[r] = 1'b0;
      end

      // target voltage in microvolts
      if (fine_step) begin
        next_s.target_uv[r] = 22'(code_clamped[r]) * 22'(`FINE_STEP_UV);
      end else begin
        next_s.target_uv[r] = 22'(code_clamped[r]) * 22'(`COARSE_STEP_UV);
      end

      // standby drive: low through reset, high while enabled and not in standby, otherwise low or released, chosen by strap
      if (en_rail[r] && !standby_req[r]) begin
        next_s.stby[r] = '{out: 1'b1, oe: 1'b1};
      end else begin
        next_s.stby[r] = '{out: 1'b0, oe: !standby_tristate};
      end

      next_s.ready[r] = en_rail[r] && !rail_fault[r] && !rail_meas[r].soft_start
                     && !rail_meas[r].shutdown;
    end

    // ----------------------------------------------------------------
    // indicator pins, per rail or shared
    // ----------------------------------------------------------------
    for (int r = 0; r < 2; r++) begin
      next_s.fault[r].out   = gpio_combine ? |rail_fault : rail_fault[r];
      next_s.fault[r].oe    = s.started[r];
      next_s.trans[r].out   = gpio_combine ? (rail_meas[0].ramp | rail_meas[1].ramp)
                            : rail_meas[r].ramp;
      next_s.trans[r].oe    = s.started[r];
      next_s.hot_pin[r].out = gpio_combine ? |s.hot : s.hot[r];
      next_s.hot_pin[r].oe  = s.started[r];
    end

    // ----------------------------------------------------------------
    // phase gating and current-sense offsets
    // ----------------------------------------------------------------
    for (int p = 0; p < 6; p++) begin
      // a skip lasts one set event; the next rising request is judged afresh
      if (pwm_req[p] && !s.req_prev[p]
          && phase_cs[p] > s.regs[p / 3].valley[11:0]) begin
        next_s.block[p] = 1'b1;
      end else if (!pwm_req[p]) begin
        next_s.block[p] = 1'b0;
      end
      next_s.req_prev[p] = pwm_req[p];

      if (!en_rail[p / 3] || s.st[p / 3] == vr_pkg::TRI_LATCH) begin
        next_s.pwm_out[p] = 1'b0;
        next_s.pwm_oe[p]  = 1'b0;
      end else if (s.abs_latch[p / 3] || s.st[p / 3] == vr_pkg::TRACK_LOW) begin
        next_s.pwm_out[p] = 1'b0;
        next_s.pwm_oe[p]  = 1'b1;
      end else begin
        // other phases keep their own turn-on, no latch from a skip
        next_s.pwm_out[p] = pwm_req[p] && !next_s.block[p];
        next_s.pwm_oe[p]  = 1'b1;
      end

      // wraps on overflow; offsets are meant to be small trims
      next_s.cs_adj[p] = phase_cs[p]
                       + {{4{s.offs[p / 2][(p % 2) * 8 + 7]}},
                          s.offs[p / 2][(p % 2) * 8 +: 8]};
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s <= '0;
      for (int r = 0; r < 2; r++) begin
        s.regs[r].cfg     <= `RST_PROTECT_CFG;
        s.regs[r].dly     <= `RST_DELAY;
        s.regs[r].oc_dly  <= `RST_DELAY;
        s.regs[r].abs_lvl <= `RST_LEVEL;
        s.regs[r].valley  <= `RST_LEVEL;
        s.regs[r].total   <= `RST_LEVEL;
        s.stby[r].oe      <= 1'b1;
      end
      for (int i = 0; i < 3; i++) begin
        s.offs[i] <= `RST_OFFSET;
      end
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata         = s.rdata;
  assign reg_rvalid        = s.rvalid;
  assign pwm_out           = s.pwm_out;
  assign pwm_oe            = s.pwm_oe;
  assign phase_cs_adj      = s.cs_adj;
  assign stage_standby_out = s.stby;
  assign fault_out         = s.fault;
  assign transition_out    = s.trans;
  assign overtemp_flag     = s.hot_pin;
  assign rail_ready_out    = s.ready;
  assign target_uv         = s.target_uv;

endmodule // vr_rail_protection_status

// file: tb/vr_rail_protection_status_assertions.sv
`timescale 1ns/1ps
// ----
// port checker
// ----
module vr_prot_checker (
  // clock and reset
  input wire logic                      clk,
  input wire logic                      resetn,
  // watched ports
  input wire logic                      reg_rd,
  input wire logic                      reg_rvalid,
  input wire logic                      fine_step,
  input wire logic                      gpio_combine,
  input wire logic [11:0]               hot_level,
  input wire logic [1:0]                standby_pin,
  input wire vr_pkg::rail_meas_t [1:0]  rail_meas,
  input wire vr_pkg::pin_drive_t [1:0]  stage_standby_out,
  input wire vr_pkg::pin_drive_t [1:0]  fault_out,
  input wire vr_pkg::pin_drive_t [1:0]  transition_out,
  input wire vr_pkg::pin_drive_t [1:0]  overtemp_flag,
  input wire logic [1:0]                rail_ready_out,
  input wire logic [1:0][21:0]          target_uv,
  input wire logic [5:0]                pwm_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  a_start_quiet: assert property ($rose(resetn) |-> !fault_out[0].oe && !rail_ready_out[0])
    else $error("fault or ready active at start");
  a_ready_soft: assert property (rail_meas[0].soft_start |=> !rail_ready_out[0])
    else $error("ready during soft start");
  a_trans_ramp: assert property (transition_out[0].oe && !gpio_combine |->
    transition_out[0].out == $past(rail_meas[0].ramp)) else $error("transition pin wrong");
  a_fine_target: assert property (fine_step && rail_meas[0].voltage_code <= 12'h280 |=>
    target_uv[0] == 22'($past(rail_meas[0].voltage_code)) * 22'd2500) else $error("fine");
  a_coarse_target: assert property (!fine_step && rail_meas[0].voltage_code <= 12'h280 |=>
    target_uv[0] == 22'($past(rail_meas[0].voltage_code)) * 22'd5000) else $error("coarse");
  a_standby_low: assert property (standby_pin[0] [*8] |-> !stage_standby_out[0].out)
    else $error("standby output still high");
  // two registers sit between the sensor and the pin, so three cycles would do; four leave one spare
  a_hot_report: assert property ((rail_meas[0].temperature > hot_level) [*4] ##0
    (overtemp_flag[0].oe && !gpio_combine) |-> overtemp_flag[0].out) else $error("hot");
  c_read: cover property (reg_rvalid);
  c_tri: cover property (!pwm_oe[0] && fault_out[0].out);
  c_hot: cover property (overtemp_flag[0].out);
endmodule // vr_prot_checker

bind vr_rail_protection_status vr_prot_checker chk (.*);

// file: tb/stage_model.sv
`timescale 1ns/1ps
// ----
// power stage model
// ----
module stage_model (
  // clock
  input wire logic             clk,
  // drive and current
  input wire logic [5:0]       pwm_oe,
  input wire logic [5:0][11:0] load,
  output logic     [5:0][11:0] phase_cs
);
  // a released stage lets its inductor current decay, so sense reads zero
  initial phase_cs = '0;
  always @(posedge clk) begin
    for (int i = 0; i < 6; i++) phase_cs[i] <= pwm_oe[i] ? load[i] : 12'h000;
  end
endmodule // stage_model

// file: tb/vr_rail_protection_status_tb.sv
`timescale 1ns/1ps
// ----
// bench
// ----
module vr_rail_protection_status_tb;
  logic clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, reg_page = 0, reg_rvalid;
  logic supply_ok_pin = 1, standby_tristate = 0, gpio_combine = 0, fine_step = 1;
  logic [7:0] reg_cmd = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [1:0] enable_pin = 2'h0, standby_pin = 2'h0, rail_ready_out;
  logic [11:0] hot_level = 12'h300, hot_hyst = 12'h020;
  logic [5:0] pwm_req = 6'h00, pwm_out, pwm_oe;
  logic [5:0][11:0] phase_cs, phase_cs_adj, load = {6{12'h010}};
  logic [1:0][21:0] target_uv;
  vr_pkg::rail_meas_t [1:0] rail_meas = {2{60'h100100010190000, 3'b000}};
  vr_pkg::pin_drive_t [1:0] stage_standby_out, fault_out, transition_out, overtemp_flag;
  int miscompares = 0, cmp_count = 0;

  always #2.5 clk = ~clk;
  vr_rail_protection_status dut (.*);
  stage_model partner (.*);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one task for both directions keeps the strobe timing in one place
  task automatic bus(input logic w, input logic p, input logic [7:0] c, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_page <= p;
    reg_cmd <= c;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 0;
    reg_rd <= 0;
    #1;
    if (!w) chk({reg_rvalid, reg_rdata}, {1'b1, d});
  endtask
  task automatic restart;
    @(posedge clk);
    enable_pin[0] <= 0;
    pwm_req <= 6'h00;
    wt(8);
    @(posedge clk);
    enable_pin[0] <= 1;
    wt(8);
    @(posedge clk);
    pwm_req <= 6'h3F;
    wt(4);
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic t_start;
    chk({fault_out, transition_out, rail_ready_out}, 10'h000);
    @(posedge clk);
    enable_pin <= 2'b11;
    wt(8);
    @(posedge clk);
    pwm_req <= 6'h3F;
    wt(4);
    chk({pwm_out, pwm_oe, stage_standby_out, rail_ready_out}, 18'h3FFFF);
  endtask
  task automatic t_regs;
    bus(0, 0, 8'h90, 16'h0000);
    bus(0, 0, 8'h95, 16'h0FFF);
    bus(0, 1, 8'h00, 16'h0000);
    bus(1, 0, 8'h90, 16'h0330);
    bus(0, 0, 8'h90, 16'h0330);
    bus(1, 0, 8'h91, 16'h0FC0);
    bus(0, 0, 8'h91, 16'h0FC0);
  endtask
  task automatic t_abs;
    bus(1, 0, 8'h95, 16'h0180);
    @(posedge clk);
    rail_meas[0].volt <= 12'h200;
    wt(4);
    chk({pwm_out, pwm_oe}, 12'hE3F);
    @(posedge clk);
    rail_meas[0].volt <= 12'h008;
    wt(6);
    chk(pwm_oe, 6'h38);
    @(posedge clk);
    rail_meas[0].volt <= 12'h100;
    wt(20);
    chk(pwm_oe, 6'h38);
    restart();
    chk({pwm_out, pwm_oe}, 12'hFFF);
  endtask
  task automatic t_oc;
    bus(1, 0, 8'h98, 16'h0100);
    bus(1, 0, 8'h93, 16'h0001);
    @(posedge clk);
    rail_meas[0].total_current <= 12'h200;
    wt(180);
    chk(pwm_oe, 6'h3F);
    for (int i = 0; i < 450 && pwm_oe[0] !== 1'b0; i++) wt(1);
    chk({pwm_oe, fault_out[0]}, 8'hE3);
    @(posedge clk);
    rail_meas[0].total_current <= 12'h010;
    restart();
  endtask
  // delays of zero give one tick, so every trip lands within about 205 cycles
  task automatic t_track;
    bus(1, 0, 8'h90, 16'h0000);
    bus(1, 0, 8'h91, 16'h0000);
    @(posedge clk);
    rail_meas[0].ramp <= 1;
    rail_meas[0].volt <= 12'h140;
    wt(250);
    chk({pwm_out, pwm_oe}, 12'hFFF);
    @(posedge clk);
    rail_meas[0].ramp <= 0;
    wt(210);
    chk({pwm_out, pwm_oe}, 12'hE3F);
    @(posedge clk);
    rail_meas[0].volt <= 12'h008;
    wt(4);
    chk(pwm_oe, 6'h38);
    @(posedge clk);
    rail_meas[0].volt <= 12'h100;
    restart();
    bus(1, 0, 8'h90, 16'h0380);
    @(posedge clk);
    rail_meas[0].volt <= 12'h0A0;
    wt(210);
    chk({pwm_oe, fault_out[0]}, 8'hE3);
    @(posedge clk);
    rail_meas[0].volt <= 12'h100;
    restart();
  endtask
  task automatic t_valley;
    bus(1, 0, 8'h97, 16'h0040);
    bus(1, 0, 8'hEB, 16'h0302);
    @(posedge clk);
    load[0] <= 12'h080;
    pwm_req <= 6'h00;
    wt(3);
    @(posedge clk);
    pwm_req <= 6'h3F;
    wt(4);
    chk({pwm_out, pwm_oe}, 12'hFBF);
    chk({phase_cs_adj[0], phase_cs_adj[1]}, 24'h082013);
  endtask
  task automatic t_status;
    @(posedge clk);
    rail_meas[0].voltage_code <= 12'h280;
    rail_meas[0].ramp <= 1;
    rail_meas[0].temperature <= 12'h400;
    wt(6);
    chk(target_uv[0], 22'd1600000);
    chk({transition_out[0], overtemp_flag[0], pwm_oe}, 10'h3FF);
    @(posedge clk);
    fine_step <= 0;
    rail_meas[0].ramp <= 0;
    rail_meas[0].soft_start <= 1;
    rail_meas[0].temperature <= 12'h2F0;
    standby_pin[0] <= 1;
    wt(10);
    chk(target_uv[0], 22'd3200000);
    chk({transition_out[0], rail_ready_out[0], stage_standby_out[0]}, 5'h09);
    chk(overtemp_flag[0], 2'h3);
    @(posedge clk);
    rail_meas[0].temperature <= 12'h2D0;
    wt(4);
    chk(overtemp_flag[0], 2'h1);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1;
    wt(1);
    t_start();
    t_regs();
    t_abs();
    t_oc();
    t_track();
    t_valley();
    t_status();
    conclude();
  end
  // the sequence needs about 1200 cycles; allow generous margin
  initial begin
    #100000;
    miscompares++;
    conclude();
  end
endmodule // vr_rail_protection_status_tb
